//--- src/serial_channel_command_pointer.sv
// How it works
// - Control/data low picks data port, high command port; channel low is A.
// - Each channel keeps eight write registers numbered zero to seven.
// - Non-zero registers take an index byte then a data byte.
// - After indexing, host may read or write the indexed register.
// - External or channel reset returns the register index to zero.
// - Any access to a non-zero register returns index to zero.
// - Command byte splits into CRC code, command code and index.
// - Command and CRC fields act in every index byte.
// - Command zero only updates the index.
// - Command one sends an abort run, only in HDLC framing.
// - Status latches on an event; command two releases it.
// - Command three resets one channel; on A also interrupt priority.
// - Command four re-arms interrupt on first received character.
// - Transmit empty interrupts; command five mutes until load or CRC done.
// - Parity and overrun latches hold until command six.
// - Command seven on channel A acts as interrupt return.
// - CRC codes: none, reset rx checker, reset tx generator, clear EOM.
// - CRC presets to ones in HDLC framing, zeros otherwise.
// - Status interrupt enable gates modem, break and EOM events.
`timescale 1ns/1ps
`default_nettype none
module serial_channel_command_pointer
  import sio_cmd_pkg::*;
(
  input wire logic clock, // System clock.
  input wire logic rst, // Asynchronous reset, active high.
  input wire host_req_t req, // Host bus access.
  output logic [7:0] rdata, // Read data, registered.
  output logic [1:0][NUM_WREGS-1:0][7:0] wreg, // Write registers per channel.
  output logic [1:0][7:0] tx_data, // Last data byte per channel.
  output logic [1:0] tx_load, // Data byte written pulse.
  output logic [1:0] rx_taken, // Data byte read pulse.
  input wire logic [1:0][7:0] rx_data, // Received byte per channel.
  input wire logic [1:0][7:0] live_status, // Live status bits.
  input wire logic [1:0] status_event, // Status change pulse.
  input wire logic [1:0] parity_err, // Parity error pulse.
  input wire logic [1:0] overrun_err, // Overrun error pulse.
  input wire logic [1:0] tx_empty, // Transmit buffer became empty.
  input wire logic [1:0] crc_done, // CRC transmission completed.
  input wire logic [1:0] rx_char, // Character received pulse.
  output logic [1:0] ext_irq, // Status interrupt request.
  output logic [1:0] tx_irq, // Transmit interrupt request.
  output logic [1:0] rx_first_armed, // First-character interrupt armed.
  output logic [1:0] abort_send, // Abort run request pulse.
  output logic [1:0] rx_crc_reset, // Receive checker preset pulse.
  output logic [1:0] tx_crc_reset, // Transmit generator preset pulse.
  output logic [1:0] crc_preset_ones, // Preset value is all ones.
  output logic [1:0] eom_clear, // Underrun/EOM latch clear pulse.
  output logic [1:0] chan_reset, // Channel reset pulse.
  output logic prio_reset, // Interrupt priority reset pulse.
  output logic int_return // Interrupt return pulse.
);

  logic [1:0][2:0] idx_r;
  logic [1:0][NUM_WREGS-1:0][7:0] wreg_r;
  logic [1:0][7:0] stat_r;
  logic [1:0] hold_r;
  logic [1:0][1:0] err_r;
  logic [1:0] txp_r;
  logic [1:0] mute_r;
  logic [1:0] rxarm_r;
  logic [1:0][7:0] txd_r;
  logic [1:0] txl_r, rxt_r, abort_r, rxcrc_r, txcrc_r, eom_r, crst_r;
  logic prio_r, ret_r;
  logic [7:0] rdata_r;
  logic [1:0] cw, dw, dr, iw, ir, hdlc;
  cmd_byte_t cb;

  //--------------------------------------------------------------
  // Access decode
  //--------------------------------------------------------------

  // Splits each access into command byte, indexed access or data port.
  always_comb
  begin
    cb = cmd_byte_t'(req.data);
    for (int c = 0; c < 2; c++)
    begin
      dw[c] = req.wr && req.cd == ADDR_DATA && req.ch == c[0];
      dr[c] = req.rd && req.cd == ADDR_DATA && req.ch == c[0];
      cw[c] = req.wr && req.cd != ADDR_DATA && req.ch == c[0] && idx_r[c] == IDX_CMD;
      iw[c] = req.wr && req.cd != ADDR_DATA && req.ch == c[0] && idx_r[c] != IDX_CMD;
      ir[c] = req.rd && req.cd != ADDR_DATA && req.ch == c[0];
      hdlc[c] = wreg_r[c][IDX_MODE][FRAMING_LSB +: 2] == FRAMING_HDLC;
    end
  end

  //--------------------------------------------------------------
  // Register index and write registers
  //--------------------------------------------------------------

  // Index per channel: loaded by a command byte, cleared after use.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      idx_r <= '0;
    else
      for (int c = 0; c < 2; c++)
      begin
        if (cw[c] && cb.cmd == CMD_CHAN_RESET)
          idx_r[c] <= IDX_CMD;
        else if (cw[c])
          idx_r[c] <= cb.idx;
        else if (iw[c] || (ir[c] && idx_r[c] != IDX_CMD))
          idx_r[c] <= IDX_CMD;
      end
  end

  // Second byte lands in the indexed register; reset clears the set.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      wreg_r <= '0;
    else
      for (int c = 0; c < 2; c++)
      begin
        if (cw[c] && cb.cmd == CMD_CHAN_RESET)
          wreg_r[c] <= '0;
        else if (cw[c])
          wreg_r[c][IDX_CMD] <= req.data;
        else if (iw[c])
          wreg_r[c][idx_r[c]] <= req.data;
      end
  end

  //--------------------------------------------------------------
  // Latched status and error flags
  //--------------------------------------------------------------

  // Status freezes on an event until re-armed; a new event beats re-arm.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      hold_r <= '0;
      stat_r <= '0;
    end
    else
      for (int c = 0; c < 2; c++)
      begin
        if (cw[c] && cb.cmd == CMD_CHAN_RESET)
          hold_r[c] <= 1'b0;
        else if (status_event[c] && (!hold_r[c] || (cw[c] && cb.cmd == CMD_EXT_REARM)))
        begin
          hold_r[c] <= 1'b1;
          stat_r[c] <= live_status[c];
        end
        else if (cw[c] && cb.cmd == CMD_EXT_REARM)
          hold_r[c] <= 1'b0;
      end
  end

  // Parity and overrun stay set until an error reset; set wins.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      err_r <= '0;
    else
      for (int c = 0; c < 2; c++)
      begin
        if (cw[c] && cb.cmd == CMD_CHAN_RESET)
          err_r[c] <= '0;
        else
          err_r[c] <= (err_r[c] & {2{!(cw[c] && cb.cmd == CMD_ERR_RESET)}})
            | {overrun_err[c], parity_err[c]};
      end
  end

  //--------------------------------------------------------------
  // Transmit and receive interrupt state
  //--------------------------------------------------------------

  // Empty buffer raises pending unless muted; a load or CRC end unmutes.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      txp_r <= '0;
      mute_r <= '0;
    end
    else
      for (int c = 0; c < 2; c++)
      begin
        if (cw[c] && cb.cmd == CMD_CHAN_RESET)
        begin
          txp_r[c] <= 1'b0;
          mute_r[c] <= 1'b0;
        end
        else if (cw[c] && cb.cmd == CMD_TX_MUTE)
        begin
          txp_r[c] <= tx_empty[c] && !mute_r[c] && wreg_r[c][IDX_ONE][TX_IE_BIT];
          mute_r[c] <= 1'b1;
        end
        else
        begin
          if (dw[c] || crc_done[c])
            mute_r[c] <= 1'b0;
          if (tx_empty[c] && !mute_r[c] && wreg_r[c][IDX_ONE][TX_IE_BIT])
            txp_r[c] <= 1'b1;
          else if (dw[c])
            txp_r[c] <= 1'b0;
        end
      end
  end

  // First-character interrupt is spent by a character and re-armed.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      rxarm_r <= '1;
    else
      for (int c = 0; c < 2; c++)
      begin
        if (cw[c] && (cb.cmd == CMD_RX_REARM || cb.cmd == CMD_CHAN_RESET))
          rxarm_r[c] <= 1'b1;
        else if (rx_char[c] && wreg_r[c][IDX_ONE][RXMODE_LSB +: 2] == RXMODE_FIRST)
          rxarm_r[c] <= 1'b0;
      end
  end

  //--------------------------------------------------------------
  // Command pulses
  //--------------------------------------------------------------

  // One-cycle strobes to the serial engines and interrupt chain.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      abort_r <= '0;
      rxcrc_r <= '0;
      txcrc_r <= '0;
      eom_r <= '0;
      crst_r <= '0;
      prio_r <= 1'b0;
      ret_r <= 1'b0;
    end
    else
    begin
      for (int c = 0; c < 2; c++)
      begin
        abort_r[c] <= cw[c] && cb.cmd == CMD_ABORT && hdlc[c];
        crst_r[c] <= cw[c] && cb.cmd == CMD_CHAN_RESET;
        rxcrc_r[c] <= cw[c] && cb.crc == CRC_RX;
        txcrc_r[c] <= cw[c] && cb.crc == CRC_TX;
        eom_r[c] <= cw[c] && cb.crc == CRC_EOM;
      end
      prio_r <= cw[CHAN_A] && cb.cmd == CMD_CHAN_RESET;
      ret_r <= cw[CHAN_A] && cb.cmd == CMD_RETURN;
    end
  end

  //--------------------------------------------------------------
  // Data port and read path
  //--------------------------------------------------------------

  // Data writes hold the byte and strobe the transmitter.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      txd_r <= '0;
      txl_r <= '0;
      rxt_r <= '0;
    end
    else
      for (int c = 0; c < 2; c++)
      begin
        txl_r[c] <= dw[c];
        rxt_r[c] <= dr[c];
        if (dw[c])
          txd_r[c] <= req.data;
      end
  end

  // Read data from the data port or the indexed readback register.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      rdata_r <= '0;
    else if (req.rd)
    begin
      if (req.cd == ADDR_DATA)
        rdata_r <= rx_data[req.ch];
      else if (idx_r[req.ch] == IDX_CMD)
        rdata_r <= hold_r[req.ch] ? stat_r[req.ch] : live_status[req.ch];
      else if (idx_r[req.ch] == IDX_ONE)
        rdata_r <= {2'h0, err_r[req.ch], 4'h0};
      else
        rdata_r <= 8'h00;
    end
  end

  assign rdata = rdata_r;
  assign wreg = wreg_r;
  assign tx_data = txd_r;
  assign tx_load = txl_r;
  assign rx_taken = rxt_r;
  assign ext_irq = hold_r & {wreg_r[1][IDX_ONE][EXT_IE_BIT], wreg_r[0][IDX_ONE][EXT_IE_BIT]};
  assign tx_irq = txp_r;
  assign rx_first_armed = rxarm_r;
  assign abort_send = abort_r;
  assign rx_crc_reset = rxcrc_r;
  assign tx_crc_reset = txcrc_r;
  assign crc_preset_ones = hdlc;
  assign eom_clear = eom_r;
  assign chan_reset = crst_r;
  assign prio_reset = prio_r;
  assign int_return = ret_r;

  //--------------------------------------------------------------
  // Checks
  //--------------------------------------------------------------

  default clocking cb_clk @(posedge clock);
  endclocking
  default disable iff (rst);

  chk_index_follows_byte: assert property (
    cw[0] && cb.cmd != CMD_CHAN_RESET |=> idx_r[0] == $past(cb.idx))
    else $error("index not loaded from command byte");
  chk_index_returns_zero: assert property (
    iw[1] |=> idx_r[1] == IDX_CMD && wreg_r[1][$past(idx_r[1])] == $past(req.data))
    else $error("indexed write did not store or clear index");
  chk_other_index_kept: assert property (
    req.ch == 1'b1 |=> $stable(idx_r[0]))
    else $error("channel B access moved channel A index");
  chk_reset_clears_index: assert property (
    cw[1] && cb.cmd == CMD_CHAN_RESET |=> idx_r[1] == IDX_CMD && chan_reset[1] ##1 !chan_reset[1])
    else $error("channel reset left index or pulse wrong");
  chk_abort_only_hdlc: assert property (
    abort_send[0] |-> $past(hdlc[0]) && $past(cw[0]))
    else $error("abort issued outside bit-oriented framing");
  chk_status_frozen: assert property (
    hold_r[0] && !(cw[0] && cb.cmd inside {CMD_EXT_REARM, CMD_CHAN_RESET}) |=> hold_r[0] && $stable(stat_r[0]))
    else $error("latched status changed while held");
  chk_error_held: assert property (
    err_r[0][0] && !(cw[0] && cb.cmd inside {CMD_ERR_RESET, CMD_CHAN_RESET}) |=> err_r[0][0])
    else $error("parity latch dropped without error reset");
  chk_tx_mute: assert property (
    cw[0] && cb.cmd == CMD_TX_MUTE && !tx_empty[0]
      ##1 (!dw[0] && !crc_done[0])[*2] |=> !tx_irq[0])
    else $error("transmit interrupt raised while muted");
  chk_return_chan_a: assert property (
    int_return |-> $past(req.ch) == CHAN_A && $past(cb.cmd) == CMD_RETURN)
    else $error("interrupt return not from channel A");
  chk_crc_codes: assert property (
    tx_crc_reset[0] |-> !rx_crc_reset[0] && !eom_clear[0]
      && $past(cw[0]) && $past(cb.crc) == CRC_TX)
    else $error("CRC reset codes overlap");

  cov_index_then_write: cover property (cw[0] && cb.idx == IDX_MODE ##[1:4] iw[0]);
  cov_status_rearm: cover property (hold_r[1] ##[1:8] !hold_r[1]);
  cov_chan_reset_a: cover property (prio_reset);
  cov_indexed_read: cover property (ir[0] && idx_r[0] == IDX_ONE);

endmodule
`default_nettype wire

//--- src/sio_cmd_pkg.sv
package sio_cmd_pkg;

  // Command byte layout: CRC reset code, basic command, register index.
  typedef struct packed {
    logic [1:0] crc;
    logic [2:0] cmd;
    logic [2:0] idx;
  } cmd_byte_t;

  // One host access on the parallel bus, one cycle wide.
  typedef struct packed {
    logic wr;
    logic rd;
    logic cd;
    logic ch;
    logic [7:0] data;
  } host_req_t;

  // Basic command codes.
  typedef enum logic [2:0] {
    CMD_NULL = 3'h0,
    CMD_ABORT = 3'h1,
    CMD_EXT_REARM = 3'h2,
    CMD_CHAN_RESET = 3'h3,
    CMD_RX_REARM = 3'h4,
    CMD_TX_MUTE = 3'h5,
    CMD_ERR_RESET = 3'h6,
    CMD_RETURN = 3'h7
  } cmd_code_t;

  // CRC reset codes.
  localparam logic [1:0] CRC_NONE = 2'h0;
  localparam logic [1:0] CRC_RX = 2'h1;
  localparam logic [1:0] CRC_TX = 2'h2;
  localparam logic [1:0] CRC_EOM = 2'h3;

  localparam int NUM_WREGS = 8;
  localparam logic [2:0] IDX_CMD = 3'h0;
  localparam logic [2:0] IDX_ONE = 3'h1;
  localparam logic [2:0] IDX_MODE = 3'h4;
  localparam logic [7:0] WREG_RESET = 8'h00;
  localparam logic ADDR_DATA = 1'b0;
  localparam logic CHAN_A = 1'b0;
  // Interrupt control register fields.
  localparam int EXT_IE_BIT = 0;
  localparam int TX_IE_BIT = 1;
  localparam int RXMODE_LSB = 3;
  localparam logic [1:0] RXMODE_FIRST = 2'h1;
  // Mode register framing field and its bit-oriented code.
  localparam int FRAMING_LSB = 4;
  localparam logic [1:0] FRAMING_HDLC = 2'h2;
  // Error latch positions in the second readback byte.
  localparam int ERR_PAR_BIT = 4;
  localparam int ERR_OVR_BIT = 5;
  // Host settle time after a channel reset.
  localparam int RESET_SETTLE_CYCLES = 4;

endpackage

//--- testbench/host_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_cpu_model
  import sio_cmd_pkg::*;
(
  input wire logic clock, // System clock.
  output var host_req_t req // Host bus access.
);
  // ------------------------------------------------------------
  // Host bus accesses
  // ------------------------------------------------------------
  logic settle_r;

  // The bus starts idle and no reset settle time is owed.
  initial
  begin
    req = '0;
    settle_r = 1'b0;
  end

  // One access: driven at an edge, held through the taking edge, then idle.
  // A channel reset leaves the channel busy, so the next access waits first.
  task automatic acc(input logic w, input logic cd, input logic ch, input logic [7:0] d);
    if (settle_r)
    begin
      repeat (RESET_SETTLE_CYCLES) @(posedge clock);
    end
    settle_r = w && cd && (d[5:3] == CMD_CHAN_RESET);
    @(posedge clock);
    req <= '{wr: w, rd: !w, cd: cd, ch: ch, data: d};
    @(posedge clock);
    req <= '0;
    #1;
  endtask
endmodule
`default_nettype wire

//--- testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sio_cmd_pkg::*;
  // ------------------------------------------------------------
  // Signals and instances
  // ------------------------------------------------------------
  logic clock = 1'b0;
  logic rst = 1'b1;
  host_req_t req;
  logic [7:0] rdata;
  logic [1:0][NUM_WREGS-1:0][7:0] wreg;
  logic [1:0][7:0] tx_data;
  logic [1:0][7:0] rx_data = 16'h7766;
  logic [1:0][7:0] live_status = 16'h00A5;
  logic [5:0][1:0] pulses = '0;
  logic [1:0] tx_load, rx_taken, ext_irq, tx_irq, rx_first_armed, abort_send;
  logic [1:0] rx_crc_reset, tx_crc_reset, crc_preset_ones, eom_clear, chan_reset;
  logic prio_reset, int_return;
  int err_total = 0;
  int checks = 0;
  int cycle_count = 0;

  // The clock toggles every half period of 2.5 ns.
  always #2.5 clock = ~clock;

  host_cpu_model host_cpu_model_i (.clock(clock), .req(req));

  serial_channel_command_pointer serial_channel_command_pointer_i (
    .clock(clock), .rst(rst), .req(req), .rdata(rdata), .wreg(wreg),
    .tx_data(tx_data), .tx_load(tx_load), .rx_taken(rx_taken), .rx_data(rx_data),
    .live_status(live_status), .status_event(pulses[0]), .parity_err(pulses[1]),
    .overrun_err(pulses[2]), .tx_empty(pulses[3]), .crc_done(pulses[4]),
    .rx_char(pulses[5]), .ext_irq(ext_irq), .tx_irq(tx_irq),
    .rx_first_armed(rx_first_armed), .abort_send(abort_send),
    .rx_crc_reset(rx_crc_reset), .tx_crc_reset(tx_crc_reset),
    .crc_preset_ones(crc_preset_ones), .eom_clear(eom_clear), .chan_reset(chan_reset),
    .prio_reset(prio_reset), .int_return(int_return));

  // ------------------------------------------------------------
  // Helper tasks
  // ------------------------------------------------------------
  // Compares a seen value with the expected one and counts both outcomes.
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic cw(input logic ch, input logic [7:0] d);
    host_cpu_model_i.acc(1'b1, 1'b1, ch, d);
  endtask

  task automatic cr(input logic ch);
    host_cpu_model_i.acc(1'b0, 1'b1, ch, 8'h00);
  endtask

  // Raises one event input for a single cycle and lets its effect land.
  task automatic evt(input int k, input logic [1:0] m);
    @(posedge clock);
    pulses[k] <= m;
    @(posedge clock);
    pulses <= '0;
    #1;
  endtask

  task automatic do_reset();
    @(posedge clock);
    rst <= 1'b1;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
  endtask

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask

  // Prints the counts and the verdict, then stops the run.
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
    begin
      $display("Run complete: PASS");
    end
    else
    begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // A hang is cut short after a generous cycle budget.
  always @(posedge clock)
  begin
    cycle_count <= cycle_count + 1;
    if (cycle_count == 4000)
    begin
      err_total++;
      end_of_test();
    end
  end

  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial
  begin
    do_reset();
    chk(rx_first_armed, 2'b11, "armed after reset");
    cw(1'b0, 8'h04);
    chk(wreg[0][0], 8'h04, "index byte stored");
    cw(1'b0, 8'h20);
    chk(wreg[0][4], 8'h20, "mode register");
    chk(crc_preset_ones, 2'b01, "preset ones");
    cw(1'b0, 8'h08);
    chk(abort_send, 2'b01, "abort in bit mode");
    chk(wreg[0][0], 8'h08, "index back to zero");
    cw(1'b1, 8'h08);
    chk(abort_send, 2'b00, "abort refused");
    done("pointer");
    cw(1'b0, 8'h01);
    cw(1'b1, 8'h02);
    chk(wreg[1][0], 8'h02, "other channel index");
    cw(1'b1, 8'h55);
    chk(wreg[1][2], 8'h55, "channel B pair");
    cw(1'b0, 8'h0B);
    chk(wreg[0][1], 8'h0B, "channel A pair");
    done("channels");
    evt(0, 2'b01);
    chk(ext_irq, 2'b01, "status interrupt");
    @(posedge clock);
    live_status[0] <= 8'h3C;
    cr(1'b0);
    chk(rdata, 8'hA5, "latched status");
    cw(1'b0, 8'h10);
    chk(ext_irq, 2'b00, "status rearm");
    cr(1'b0);
    chk(rdata, 8'h3C, "live status");
    evt(0, 2'b10);
    chk(ext_irq, 2'b00, "disabled status");
    done("status");
    evt(1, 2'b01);
    evt(2, 2'b01);
    cw(1'b0, 8'h01);
    cr(1'b0);
    chk(rdata, 8'h30, "error latches");
    cr(1'b0);
    chk(rdata, 8'h3C, "index zero after read");
    cw(1'b0, 8'h31);
    cr(1'b0);
    chk(rdata, 8'h00, "errors cleared");
    done("errors");
    evt(3, 2'b01);
    chk(tx_irq, 2'b01, "tx empty");
    cw(1'b0, 8'h28);
    chk(tx_irq, 2'b00, "tx cleared");
    evt(3, 2'b01);
    chk(tx_irq, 2'b00, "tx muted");
    host_cpu_model_i.acc(1'b1, 1'b0, 1'b0, 8'h9C);
    chk(tx_load, 2'b01, "data write");
    chk(tx_data[0], 8'h9C, "data byte");
    evt(3, 2'b01);
    chk(tx_irq, 2'b01, "unmuted by load");
    cw(1'b0, 8'h28);
    evt(4, 2'b01);
    evt(3, 2'b01);
    chk(tx_irq, 2'b01, "unmuted by crc");
    host_cpu_model_i.acc(1'b0, 1'b0, 1'b1, 8'h00);
    chk(rdata, 8'h77, "data read");
    chk(rx_taken, 2'b10, "data taken");
    done("transmit");
    evt(5, 2'b01);
    chk(rx_first_armed, 2'b10, "first char used");
    cw(1'b0, 8'h20);
    chk(rx_first_armed, 2'b11, "first char rearmed");
    cw(1'b0, 8'h00);
    chk({abort_send, chan_reset, prio_reset, int_return, eom_clear}, 8'h00, "null");
    for (int k = 0; k < 4; k++)
    begin
      cw(1'b0, {k[1:0], 6'h00});
      chk({rx_crc_reset[0], tx_crc_reset[0], eom_clear[0]}, {k == 1, k == 2, k == 3}, "crc");
    end
    cw(1'b0, 8'h38);
    chk(int_return, 1'b1, "return on A");
    cw(1'b1, 8'h38);
    chk(int_return, 1'b0, "return on B");
    done("commands");
    cw(1'b1, 8'h18);
    chk({chan_reset, prio_reset}, 3'b100, "reset B");
    chk(wreg[1][2], 8'h00, "B cleared");
    cw(1'b0, 8'h18);
    chk({chan_reset, prio_reset}, 3'b011, "reset A");
    chk(crc_preset_ones, 2'b00, "A cleared");
    cw(1'b0, 8'h05);
    do_reset();
    cw(1'b0, 8'h02);
    chk(wreg[0][0], 8'h02, "index zero after reset");
    chk(wreg[0][5], 8'h00, "no stale index");
    done("reset");
    end_of_test();
  end
endmodule
`default_nettype wire
